// file: hw/timer_hw_limit_monostable.sv
// timer with edge-triggered hardware-limit reset and monostable start
//
// Contract
// - hardware-limit edge clears the count early
// - modes 00011/00100/00101: both, rise, fall reset
// - early reset restarts pwm two clocks later
// - monostable waits idle for a start edge
// - monostable stops at period match
// - modes 10001/10010/10011: rise, fall, both start
// - start edge drives pwm active
// - no pwm reassert at monostable match
// - edges ignored while monostable counts
`timescale 1ns/1ps
`default_nettype none
module timer_hw_limit_monostable (
    // clock, reset, enable
    input  wire logic                  core_clk,
    input  wire logic                  srst,
    input  wire logic                  clkEn,
    // software settings, sampled asynchronously to this clock
    input  wire tmr_limit_pkg::tmrCfg_t cfgIn,
    // external reset pin
    input  wire logic                  extResetInput,
    // status towards software and the pwm channel
    output tmr_limit_pkg::tmrStat_t     statOut
);
    tmr_limit_pkg::tmrState_t s_q;
    tmr_limit_pkg::tmrState_t s_d;

    logic riseEdge;
    logic fallEdge;
    logic hlMode;
    logic msMode;
    logic hlHit;
    logic msHit;
    logic atPeriod;

    // edge detection reads only the second stage and its delayed copy
    always_comb begin
        riseEdge = s_q.ersSync2 & ~s_q.ersPrev;
        fallEdge = ~s_q.ersSync2 & s_q.ersPrev;
        hlMode = (s_q.mode == tmr_limit_pkg::MODE_HL_BOTH)
              || (s_q.mode == tmr_limit_pkg::MODE_HL_RISE)
              || (s_q.mode == tmr_limit_pkg::MODE_HL_FALL);
        msMode = (s_q.mode == tmr_limit_pkg::MODE_MS_RISE)
              || (s_q.mode == tmr_limit_pkg::MODE_MS_FALL)
              || (s_q.mode == tmr_limit_pkg::MODE_MS_BOTH);
        hlHit = ((s_q.mode == tmr_limit_pkg::MODE_HL_BOTH)
                 && (riseEdge | fallEdge))
             || ((s_q.mode == tmr_limit_pkg::MODE_HL_RISE) && riseEdge)
             || ((s_q.mode == tmr_limit_pkg::MODE_HL_FALL)
                 && fallEdge);
        msHit = ((s_q.mode == tmr_limit_pkg::MODE_MS_RISE) && riseEdge)
             || ((s_q.mode == tmr_limit_pkg::MODE_MS_FALL) && fallEdge)
             || ((s_q.mode == tmr_limit_pkg::MODE_MS_BOTH)
                 && (riseEdge | fallEdge));
        atPeriod = (s_q.stat.count == s_q.period);
    end

    // next state: one copy of the whole state, filled in one place
    always_comb begin
        s_d = s_q;
        s_d.stat.matchPulse = 1'b0;
        // the pin crosses in through two flops; settings take one flop,
        // being quasi-static while the timer is enabled
        s_d.ersSync1 = extResetInput;
        s_d.ersSync2 = s_q.ersSync1;
        s_d.ersPrev = s_q.ersSync2;
        s_d.mode = cfgIn.mode;
        s_d.enable = cfgIn.enable;
        s_d.period = cfgIn.period;
        s_d.duty = cfgIn.duty;
        if (!s_q.enable) begin
            s_d.stat.count = tmr_limit_pkg::CNT_RST;
            s_d.stat.pwmOut = 1'b0;
            s_d.stat.running = 1'b0;
            s_d.msState = tmr_limit_pkg::MS_IDLE;
            s_d.pwmDly = 2'h0;
        end else if (msMode) begin
            case (s_q.msState)
                tmr_limit_pkg::MS_IDLE: begin
                    // count held until a qualifying start edge
                    s_d.stat.running = 1'b0;
                    if (msHit) begin
                        s_d.msState = tmr_limit_pkg::MS_RUN;
                        s_d.stat.count = tmr_limit_pkg::CNT_RST;
                        s_d.stat.running = 1'b1;
                        s_d.stat.pwmOut = 1'b1;
                    end
                end
                tmr_limit_pkg::MS_RUN: begin
                    // further edges fall through untouched here
                    if (atPeriod) begin
                        s_d.msState = tmr_limit_pkg::MS_IDLE;
                        s_d.stat.running = 1'b0;
                        s_d.stat.matchPulse = 1'b1;
                        s_d.stat.pwmOut = 1'b0;
                    end else begin
                        s_d.stat.count = s_q.stat.count + 8'h01;
                        if (s_q.stat.count + 8'h01 >= s_q.duty)
                            s_d.stat.pwmOut = 1'b0;
                    end
                end
                default: s_d.msState = tmr_limit_pkg::MS_IDLE;
            endcase
        end else if (hlMode) begin
            s_d.stat.running = 1'b1;
            s_d.msState = tmr_limit_pkg::MS_IDLE;
            if (s_q.pwmDly != 2'h0) begin
                // pwm held low while the restart delay runs
                s_d.pwmDly = s_q.pwmDly - 2'h1;
                if (s_q.pwmDly == 2'h1)
                    s_d.stat.pwmOut = (s_q.duty != 8'h00);
            end
            if (hlHit) begin
                s_d.stat.count = tmr_limit_pkg::CNT_RST;
                s_d.pwmDly = tmr_limit_pkg::DLY_LOAD;
                s_d.stat.pwmOut = 1'b0;
            end else if (atPeriod) begin
                s_d.stat.count = tmr_limit_pkg::CNT_RST;
                s_d.stat.matchPulse = 1'b1;
                if (s_q.pwmDly == 2'h0)
                    s_d.stat.pwmOut = (s_q.duty != 8'h00);
            end else begin
                s_d.stat.count = s_q.stat.count + 8'h01;
                if ((s_q.stat.count + 8'h01 >= s_q.duty)
                    && (s_q.pwmDly == 2'h0))
                    s_d.stat.pwmOut = 1'b0;
            end
        end else begin
            // other modes belong elsewhere; hold still
            s_d.stat.running = 1'b0;
            s_d.stat.pwmOut = 1'b0;
        end
    end

    // registered state; clock enable freezes everything
    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_q <= '0;
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    assign statOut = s_q.stat;

    // checks sample the registered state, so each consequent looks one
    // enabled edge after the cycle that decided it
    chk_sync_chain: assert property (
        @(posedge core_clk) disable iff (srst)
        clkEn
        |=> (s_q.ersSync2 == $past(s_q.ersSync1))
            && (s_q.ersPrev == $past(s_q.ersSync2)))
        else $error("pin synchroniser stages out of order");

    chk_hl_clear: assert property (
        @(posedge core_clk) disable iff (srst)
        clkEn && s_q.enable && hlMode && hlHit
        |=> s_q.stat.count == 8'h00)
        else $error("count not cleared by hardware-limit edge");

    // the wrong polarity must leave the count stepping as usual
    chk_hl_rise_only: assert property (
        @(posedge core_clk) disable iff (srst)
        clkEn && s_q.enable && fallEdge && !atPeriod
        && (s_q.mode == tmr_limit_pkg::MODE_HL_RISE)
        |=> s_q.stat.count == $past(s_q.stat.count) + 8'h01)
        else $error("rise mode reacted to falling edge");

    chk_hl_fall_only: assert property (
        @(posedge core_clk) disable iff (srst)
        clkEn && s_q.enable && riseEdge && !atPeriod
        && (s_q.mode == tmr_limit_pkg::MODE_HL_FALL)
        |=> s_q.stat.count == $past(s_q.stat.count) + 8'h01)
        else $error("fall mode reacted to rising edge");

    // early reset drops the pulse, then brings it back two clocks later
    chk_pwm_dip: assert property (
        @(posedge core_clk) disable iff (srst)
        clkEn && s_q.enable && hlMode && hlHit
        |=> !s_q.stat.pwmOut)
        else $error("pwm not dropped by early reset");

    chk_pwm_restart: assert property (
        @(posedge core_clk) disable iff (srst)
        clkEn && s_q.enable && hlMode && hlHit
        ##1 clkEn && s_q.enable && hlMode && !hlHit
        ##1 clkEn && s_q.enable && hlMode && !hlHit && (s_q.duty != 8'h00)
        |=> s_q.stat.pwmOut)
        else $error("pwm not restarted two clocks after reset");

    chk_ms_idle: assert property (
        @(posedge core_clk) disable iff (srst)
        clkEn && s_q.enable && msMode && !msHit
        && (s_q.msState == tmr_limit_pkg::MS_IDLE)
        |=> $stable(s_q.stat.count))
        else $error("monostable counted without start edge");

    // only a running timer stops at the match; an idle one may restart
    chk_ms_stop: assert property (
        @(posedge core_clk) disable iff (srst)
        clkEn && s_q.enable && msMode && atPeriod
        && (s_q.msState == tmr_limit_pkg::MS_RUN)
        |=> (s_q.msState == tmr_limit_pkg::MS_IDLE) && !s_q.stat.running)
        else $error("monostable kept running past period");

    chk_ms_start: assert property (
        @(posedge core_clk) disable iff (srst)
        clkEn && s_q.enable && msMode && msHit
        && (s_q.msState == tmr_limit_pkg::MS_IDLE)
        |=> s_q.stat.pwmOut && s_q.stat.running)
        else $error("start edge did not drive pwm");

    chk_ms_no_rearm: assert property (
        @(posedge core_clk) disable iff (srst)
        clkEn && s_q.enable && msMode && atPeriod
        && (s_q.msState == tmr_limit_pkg::MS_RUN)
        |=> !s_q.stat.pwmOut)
        else $error("pwm reasserted at monostable match");

    chk_ms_ignore: assert property (
        @(posedge core_clk) disable iff (srst)
        clkEn && s_q.enable && msMode && !atPeriod && msHit
        && (s_q.msState == tmr_limit_pkg::MS_RUN)
        |=> s_q.stat.count == $past(s_q.stat.count) + 8'h01)
        else $error("edge disturbed running monostable");
endmodule
`default_nettype wire

// file: hw/tmr_limit_pkg.sv
// package: modes, widths and state layout of the hardware-limit/monostable timer
package tmr_limit_pkg;
    localparam int CNT_W = 8;
    localparam int MODE_W = 5;
    localparam logic [4:0] MODE_HL_BOTH = 5'h03;
    localparam logic [4:0] MODE_HL_RISE = 5'h04;
    localparam logic [4:0] MODE_HL_FALL = 5'h05;
    localparam logic [4:0] MODE_MS_RISE = 5'h11;
    localparam logic [4:0] MODE_MS_FALL = 5'h12;
    localparam logic [4:0] MODE_MS_BOTH = 5'h13;
    localparam int PWM_RESTART_DLY = 2;
    localparam logic [1:0] DLY_LOAD = 2'h2;
    localparam logic [7:0] CNT_RST = 8'h00;

    typedef enum logic [1:0] {MS_IDLE, MS_RUN} msState_t;

    typedef struct packed {
        logic [MODE_W-1:0] mode;
        logic              enable;
        logic [CNT_W-1:0]  period;
        logic [CNT_W-1:0]  duty;
    } tmrCfg_t;

    typedef struct packed {
        logic [CNT_W-1:0]  count;
        logic              matchPulse;
        logic              pwmOut;
        logic              running;
    } tmrStat_t;

    typedef struct packed {
        logic              ersSync1;
        logic              ersSync2;
        logic              ersPrev;
        msState_t          msState;
        logic [1:0]        pwmDly;
        logic [MODE_W-1:0] mode;
        logic              enable;
        logic [CNT_W-1:0]  period;
        logic [CNT_W-1:0]  duty;
        tmrStat_t          stat;
    } tmrState_t;
endpackage

// file: sim/ext_reset_src.sv
// far-side model: source of the external reset pin
`timescale 1ns/1ps
`default_nettype none
module ext_reset_src (
    // timer clock
    input  wire logic core_clk,
    // pin towards the timer
    output var logic  pin
);
    initial pin = 1'b0;
    // pin moves just after a falling edge, never near the sampling edge
    task automatic move(input logic lvl);
        @(negedge core_clk);
        pin = lvl;
    endtask
endmodule
`default_nettype wire

// file: sim/timer_hw_limit_monostable_test.sv
// bench for the hardware-limit and monostable timer
`timescale 1ns/1ps
`default_nettype none
module timer_hw_limit_monostable_test;
    logic                    core_clk;
    logic                    srst;
    logic                    clkEn;
    tmr_limit_pkg::tmrCfg_t  cfgIn;
    logic                    extResetInput;
    tmr_limit_pkg::tmrStat_t statOut;
    int                      error_cnt;
    int                      checked;
    ext_reset_src src_u (.core_clk(core_clk), .pin(extResetInput));
    // clock enable driven so that the freeze path is exercised too
    timer_hw_limit_monostable dut_u (
        .core_clk     (core_clk),
        .srst         (srst),
        .clkEn        (clkEn),
        .cfgIn        (cfgIn),
        .extResetInput(extResetInput),
        .statOut      (statOut)
    );
    // 40 MHz timer clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // reset between cases so no state leaks from one mode to the next
    task automatic setup(input logic [4:0] m, input logic [7:0] p,
                         input logic [7:0] d, input logic lvl);
        srst = 1'b1;
        cfgIn = '{mode: m, enable: 1'b0, period: p, duty: d};
        src_u.move(lvl);
        cyc(6);
        srst = 1'b0;
        cyc(2);
        cfgIn.enable = 1'b1;
    endtask
    // one pin edge; watch pwm over the restart window
    task automatic hl_edge(input logic lvl, input logic clr);
        logic sawLow;
        logic low;
        sawLow = 1'b0;
        src_u.move(lvl);
        repeat (8) begin
            cyc(1);
            if (statOut.pwmOut !== 1'b1) sawLow = 1'b1;
        end
        // a cleared count sits at 5 here, an uncleared one far above 10
        low = (statOut.count < 8'h0A);
        check("hl count cleared", 8'(low), 8'(clr));
        check("hl pwm dip", 8'(sawLow), 8'(clr));
        check("hl pwm restarted", 8'(statOut.pwmOut), 8'h01);
        cyc(12);
    endtask
    // duty above period: pwm stays high once the first match sets it
    task automatic hl_case(input logic [4:0] m, input logic r, input logic f);
        setup(m, 8'hC8, 8'hFF, 1'b0);
        cyc(250);
        hl_edge(1'b1, r);
        hl_edge(1'b0, f);
    endtask
    // idle until the start edge, then a full extra pulse during the run
    task automatic ms_case(input logic [4:0] m, input logic idle);
        setup(m, 8'h05, 8'h10, idle);
        cyc(10);
        check("ms waits idle", 8'(statOut.running), 8'h00);
        check("ms count held", statOut.count, 8'h00);
        src_u.move(~idle);
        cyc(1);
        src_u.move(idle);
        src_u.move(~idle);
        src_u.move(idle);
        check("ms started", 8'(statOut.running), 8'h01);
        check("ms pwm active", 8'(statOut.pwmOut), 8'h01);
        cyc(2);
        check("ms edge ignored", statOut.count, 8'h03);
        check("ms pwm undisturbed", 8'(statOut.pwmOut), 8'h01);
        cyc(3);
        check("ms stop count", statOut.count, 8'h05);
        check("ms match pulse", 8'(statOut.matchPulse), 8'h01);
        check("ms stopped", 8'(statOut.running), 8'h00);
        check("ms single pulse", 8'(statOut.pwmOut), 8'h00);
        cyc(6);
        check("ms stays stopped", statOut.count, 8'h05);
        check("ms pulse ended", 8'(statOut.matchPulse), 8'h00);
    endtask
    // clock enable low must freeze the running count
    task automatic freeze_case();
        setup(tmr_limit_pkg::MODE_HL_BOTH, 8'hC8, 8'hFF, 1'b0);
        cyc(20);
        clkEn = 1'b0;
        cyc(5);
        check("frozen count", statOut.count, 8'h13);
        clkEn = 1'b1;
        cyc(1);
        check("thawed count", statOut.count, 8'h14);
    endtask
    // an undecoded mode holds the timer and ignores the pin
    task automatic other_case();
        setup(5'h00, 8'h05, 8'h10, 1'b0);
        cyc(4);
        src_u.move(1'b1);
        cyc(6);
        check("other mode count", statOut.count, 8'h00);
        check("other mode pwm", 8'(statOut.pwmOut), 8'h00);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        #(25 * 20000);
        error_cnt++;
        close_out();
    end
    initial begin
        error_cnt = 0;
        checked = 0;
        srst = 1'b1;
        cfgIn = '0;
        clkEn = 1'b1;
        cyc(8);
        check("reset count", statOut.count, 8'h00);
        check("reset pwm", 8'(statOut.pwmOut), 8'h00);
        srst = 1'b0;
        cyc(2);
        check("released count", statOut.count, 8'h00);
        check("released run", 8'(statOut.running), 8'h00);
        hl_case(tmr_limit_pkg::MODE_HL_BOTH, 1'b1, 1'b1);
        hl_case(tmr_limit_pkg::MODE_HL_RISE, 1'b1, 1'b0);
        hl_case(tmr_limit_pkg::MODE_HL_FALL, 1'b0, 1'b1);
        ms_case(tmr_limit_pkg::MODE_MS_RISE, 1'b0);
        ms_case(tmr_limit_pkg::MODE_MS_FALL, 1'b1);
        ms_case(tmr_limit_pkg::MODE_MS_BOTH, 1'b0);
        freeze_case();
        other_case();
        close_out();
    end
endmodule
`default_nettype wire
